/* File: cea_core_energy_accumulator.sv */
/*
  Core energy and performance counters: free-running cycle counter,
  max-performance count with read-only and guest-scaled view, energy
  accumulator fed once per sample period, and identification outputs.
  Assumes all inputs synchronous to core_clk and one request per port per cycle.
*/
`timescale 1ns/1ps
module cea_core_energy_accumulator
  import cea_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        por_n,
  input  wire logic        core_active,
  input  wire cea_energy_t energy_in,
  input  wire cea_ratio_t  guest_cycle_scale_ratio,
  input  wire logic        reg_rd_req,
  input  wire cea_addr_t   reg_rd_addr,
  input  wire logic        reg_rd_guest,
  input  wire logic        reg_wr_req,
  input  wire cea_addr_t   reg_wr_addr,
  input  wire cea_word_t   reg_wr_data,
  input  wire logic        cycle_counter_read_instr,
  output cea_word_t        reg_rd_data,
  output logic             reg_rd_valid,
  output logic             reg_rd_err,
  output logic             reg_wr_err,
  output cea_word_t        cycle_rd_data,
  output logic             cycle_rd_valid,
  output logic [31:0]      sample_to_cycle_ratio,
  output logic             power_reporting_support_flag
);

  typedef struct packed {
    cea_word_t   free_running_cycle_counter;
    cea_word_t   max_perf_clock_count;
    cea_acc_t    core_energy_accumulator;
    cea_word_t   rd_data;
    logic        rd_valid;
    logic        rd_err;
    logic        wr_err;
    cea_word_t   cyc_data;
    logic        cyc_valid;
    logic [31:0] id_ratio;
    logic        id_power;
  } cea_state_s;

  cea_state_s state;
  cea_state_s next_state;
  logic       sample_tick;

  cea_tick_if tick_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // sample period timer
  cea_sample_timer u_timer (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .tick_bus (tick_bus.timer)
  );

  assign sample_tick = tick_bus.tick;

  ////////////////////////////////////////////////////////////////////////////
  // next state: counters, register reads and writes, resets
  always_comb begin
    next_state           = state;
    next_state.rd_valid  = 1'b0;
    next_state.rd_err    = 1'b0;
    next_state.wr_err    = 1'b0;
    next_state.cyc_valid = 1'b0;

    // free-running cycle counter
    next_state.free_running_cycle_counter =
      state.free_running_cycle_counter + 64'h0000_0000_0000_0001;

    // max-performance count runs while the core is active
    if (core_active) begin
      next_state.max_perf_clock_count =
        state.max_perf_clock_count + 64'h0000_0000_0000_0001;
    end

    // energy added once per sample period, modulo the width
    if (sample_tick) begin
      next_state.core_energy_accumulator = state.core_energy_accumulator
        + cea_acc_t'(energy_in);
    end

    // writes: only the writable count accepts data
    if (reg_wr_req) begin
      if (reg_wr_addr == ADDR_MAX_PERF) begin
        next_state.max_perf_clock_count = reg_wr_data;
      end else begin
        next_state.wr_err = 1'b1;
      end
    end

    // reads, answered one cycle after the request
    if (reg_rd_req) begin
      next_state.rd_valid = 1'b1;
      unique case (reg_rd_addr)
        ADDR_CYCLE_COUNT: begin
          next_state.rd_data = state.free_running_cycle_counter;
        end
        ADDR_MAX_PERF: begin
          next_state.rd_data = state.max_perf_clock_count;
        end
        ADDR_MAX_PERF_RO: begin
          if (reg_rd_guest) begin
            next_state.rd_data = cea_scale(state.max_perf_clock_count, guest_cycle_scale_ratio);
          end else begin
            next_state.rd_data = state.max_perf_clock_count;
          end
        end
        ADDR_ENERGY_ACC: begin
          next_state.rd_data = {{(64-ACC_W){1'b0}}, state.core_energy_accumulator};
        end
        ADDR_FULL_SCALE: begin
          next_state.rd_data = ACC_FULL_SCALE;
        end
        default: begin
          next_state.rd_data = WORD_RESET;
          next_state.rd_err  = 1'b1;
        end
      endcase
    end

    // dedicated cycle counter read
    if (cycle_counter_read_instr) begin
      next_state.cyc_valid = 1'b1;
      next_state.cyc_data  = state.free_running_cycle_counter;
    end

    // identification values are constants
    next_state.id_ratio = ID_RATIO;
    next_state.id_power = ID_POWER_FLAG;

    // warm reset clears everything but the accumulator and the identification values
    if (!reset_n) begin
      next_state.free_running_cycle_counter = WORD_RESET;
      next_state.max_perf_clock_count       = WORD_RESET;
      next_state.core_energy_accumulator    = state.core_energy_accumulator;
      next_state.rd_data                    = WORD_RESET;
      next_state.rd_valid                   = 1'b0;
      next_state.rd_err                     = 1'b0;
      next_state.wr_err                     = 1'b0;
      next_state.cyc_data                   = WORD_RESET;
      next_state.cyc_valid                  = 1'b0;
    end
    // power-on alone clears the accumulator
    if (!por_n) begin
      next_state.core_energy_accumulator = ACC_POWER_ON;
    end
  end

  always_ff @(posedge core_clk) begin
    state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign reg_rd_data                  = state.rd_data;
  assign reg_rd_valid                 = state.rd_valid;
  assign reg_rd_err                   = state.rd_err;
  assign reg_wr_err                   = state.wr_err;
  assign cycle_rd_data                = state.cyc_data;
  assign cycle_rd_valid               = state.cyc_valid;
  assign sample_to_cycle_ratio        = state.id_ratio;
  assign power_reporting_support_flag = state.id_power;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n || !por_n);

  sequence s_ro_read(logic guest);
    reg_rd_req && reg_rd_addr == ADDR_MAX_PERF_RO && reg_rd_guest == guest;
  endsequence

  a_cycle_count_step: assert property (reset_n |-> ##4
      state.free_running_cycle_counter ==
      $past(state.free_running_cycle_counter, 4) + 64'h0000_0000_0000_0004)
    else $error("cycle counter did not advance one per cycle");
  a_cycle_read_value: assert property (cycle_counter_read_instr |=>
      cycle_rd_valid && cycle_rd_data == $past(state.free_running_cycle_counter))
    else $error("cycle counter read returned wrong value");
  a_view_host_read: assert property (s_ro_read(1'b0) |=>
      reg_rd_valid && !reg_rd_err && reg_rd_data == $past(state.max_perf_clock_count))
    else $error("host read of read-only view wrong");
  a_view_guest_scaled: assert property (s_ro_read(1'b1) |=> reg_rd_valid &&
      reg_rd_data == cea_scale($past(state.max_perf_clock_count),
                               $past(guest_cycle_scale_ratio)))
    else $error("guest read of read-only view not scaled");
  a_view_no_write: assert property (reg_wr_req && reg_wr_addr == ADDR_MAX_PERF_RO
      |=> reg_wr_err && state.max_perf_clock_count ==
      $past(state.max_perf_clock_count) + 64'($past(core_active)))
    else $error("write through read-only view changed the count");
  a_acc_add_sample: assert property (sample_tick |=> state.core_energy_accumulator ==
      cea_acc_t'($past(state.core_energy_accumulator) + cea_acc_t'($past(energy_in))))
    else $error("accumulator did not add sample energy");
  a_acc_wrap_zero: assert property (sample_tick &&
      state.core_energy_accumulator == ACC_FULL_SCALE[ACC_W-1:0] && energy_in == 16'h0001
      |=> state.core_energy_accumulator == ACC_POWER_ON)
    else $error("accumulator did not wrap through zero");
  a_acc_hold_idle: assert property (!sample_tick |=>
      $stable(state.core_energy_accumulator))
    else $error("accumulator changed outside a sample tick");
  a_acc_keep_reset: assert property (disable iff (!por_n)
      !reset_n |=> state.core_energy_accumulator == $past(state.core_energy_accumulator))
    else $error("warm reset disturbed the accumulator");
  a_full_scale_read: assert property (reg_rd_req && reg_rd_addr == ADDR_FULL_SCALE |=>
      reg_rd_data == {{(64-ACC_W){1'b0}}, {ACC_W{1'b1}}})
    else $error("full-scale read wrong");
  a_id_values_const: assert property ($past(reset_n) |->
      sample_to_cycle_ratio == ID_RATIO && power_reporting_support_flag)
    else $error("identification outputs wrong");

endmodule

/* File: cea_pkg.sv */
/*
  Shared constants, types and helpers for the core energy accumulator block.
  Assumes a single 200 MHz core clock and model-register style access.
*/
package cea_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_PS  = 5000;  // 200 MHz core clock
  localparam int unsigned SAMPLE_TIME_NS = 2000;  // energy sample period
  // longest whole number of cycles that fits in the sample period
  localparam int unsigned SAMPLE_CYCLES  = (SAMPLE_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned SAMPLE_CNT_W   = 9;

  typedef logic [SAMPLE_CNT_W-1:0] cea_sample_t;
  localparam cea_sample_t SAMPLE_LAST  = cea_sample_t'(SAMPLE_CYCLES - 1);
  localparam cea_sample_t SAMPLE_RESET = 9'h000;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned ACC_W      = 48;  // implemented accumulator width
  localparam int unsigned ENERGY_W   = 16;  // energy per sample period
  localparam int unsigned RATIO_W    = 40;  // guest scale, 8.32 fixed point
  localparam int unsigned RATIO_FRAC = 32;

  typedef logic [31:0]         cea_addr_t;
  typedef logic [63:0]         cea_word_t;
  typedef logic [ACC_W-1:0]    cea_acc_t;
  typedef logic [ENERGY_W-1:0] cea_energy_t;
  typedef logic [RATIO_W-1:0]  cea_ratio_t;

  ////////////////////////////////////////////////////////////////////////////
  // model register addresses
  localparam cea_addr_t ADDR_CYCLE_COUNT = 32'h0000_0010;
  localparam cea_addr_t ADDR_MAX_PERF    = 32'h0000_00E7;
  localparam cea_addr_t ADDR_MAX_PERF_RO = 32'hC000_00E7;
  localparam cea_addr_t ADDR_ENERGY_ACC  = 32'hC001_0E00;
  localparam cea_addr_t ADDR_FULL_SCALE  = 32'hC001_0E01;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset and constant read-backs
  localparam cea_word_t   WORD_RESET     = 64'h0000_0000_0000_0000;
  localparam cea_acc_t    ACC_POWER_ON   = 48'h0000_0000_0000;
  localparam cea_word_t   ACC_FULL_SCALE = {{(64-ACC_W){1'b0}}, {ACC_W{1'b1}}};
  localparam logic [31:0] ID_RATIO       = 32'(SAMPLE_CYCLES);
  localparam logic        ID_POWER_FLAG  = 1'b1;

  // guest view of a count: count times 8.32 ratio, fraction dropped
  function automatic cea_word_t cea_scale(input cea_word_t count, input cea_ratio_t ratio);
    logic [63+RATIO_W:0] prod;
    prod = count * ratio;
    return prod[63+RATIO_FRAC:RATIO_FRAC];
  endfunction

endpackage

/* File: cea_tick_if.sv */
/*
  Carrier for the sample-period tick between the timer and the accumulator.
  Assumes both ends run on the core clock.
*/
`timescale 1ns/1ps
interface cea_tick_if;
  logic tick;  // one-cycle pulse at the end of each sample period

  modport timer (output tick);
  modport user  (input  tick);
endinterface

/* File: cea_sample_timer.sv */
/*
  Sample period timer: one tick pulse every sample period.
  Assumes synchronous active-low reset on the core clock.
*/
`timescale 1ns/1ps
module cea_sample_timer
  import cea_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  cea_tick_if.timer tick_bus
);

  typedef struct packed {
    cea_sample_t count;
    logic        tick;
  } cea_timer_s;

  cea_timer_s state;
  cea_timer_s next_state;

  ////////////////////////////////////////////////////////////////////////////
  // count cycles, pulse on the last one of each period
  always_comb begin
    next_state      = state;
    next_state.tick = 1'b0;
    if (state.count == SAMPLE_LAST) begin
      next_state.count = SAMPLE_RESET;
      next_state.tick  = 1'b1;
    end else begin
      next_state.count = state.count + 9'h001;
    end
    if (!reset_n) begin
      next_state = '{count: SAMPLE_RESET, tick: 1'b0};
    end
  end

  always_ff @(posedge core_clk) begin
    state <= next_state;
  end

  assign tick_bus.tick = state.tick;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  localparam int TICK_SPAN = SAMPLE_CYCLES;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_tick_spacing_min: assert property (state.tick |=> !state.tick [*8])
    else $error("sample ticks closer than expected");
  a_tick_period_max: assert property (state.tick |-> ##[1:TICK_SPAN] state.tick)
    else $error("sample tick missing within one period");

endmodule

/* File: cea_core_energy_accumulator_tb.sv */
/*
  Self-checking bench for the core energy accumulator top module.
  Assumes the bench drives every input itself and owns reset and power-on.
*/
`timescale 1ns/1ps
module cea_core_energy_accumulator_tb;
  import cea_pkg::*;

  logic        core_clk, reset_n, por_n, core_active;
  logic        reg_rd_req, reg_rd_guest, reg_wr_req, cycle_counter_read_instr;
  cea_energy_t energy_in;
  cea_ratio_t  guest_cycle_scale_ratio;
  cea_addr_t   reg_rd_addr, reg_wr_addr;
  cea_word_t   reg_wr_data, reg_rd_data, cycle_rd_data;
  logic        reg_rd_valid, reg_rd_err, reg_wr_err, cycle_rd_valid;
  logic [31:0] sample_to_cycle_ratio;
  logic        power_reporting_support_flag;
  int          n_mismatch, check_count, k;
  logic [31:0] seed;
  cea_word_t   d, d0, v, t0, t1, jmax, p;
  cea_ratio_t  r;
  logic        e;

  cea_core_energy_accumulator cea_core_energy_accumulator_inst (
    .core_clk                     (core_clk),
    .reset_n                      (reset_n),
    .por_n                        (por_n),
    .core_active                  (core_active),
    .energy_in                    (energy_in),
    .guest_cycle_scale_ratio      (guest_cycle_scale_ratio),
    .reg_rd_req                   (reg_rd_req),
    .reg_rd_addr                  (reg_rd_addr),
    .reg_rd_guest                 (reg_rd_guest),
    .reg_wr_req                   (reg_wr_req),
    .reg_wr_addr                  (reg_wr_addr),
    .reg_wr_data                  (reg_wr_data),
    .cycle_counter_read_instr     (cycle_counter_read_instr),
    .reg_rd_data                  (reg_rd_data),
    .reg_rd_valid                 (reg_rd_valid),
    .reg_rd_err                   (reg_rd_err),
    .reg_wr_err                   (reg_wr_err),
    .cycle_rd_data                (cycle_rd_data),
    .cycle_rd_valid               (cycle_rd_valid),
    .sample_to_cycle_ratio        (sample_to_cycle_ratio),
    .power_reporting_support_flag (power_reporting_support_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  always #2.5 core_clk = ~core_clk;
  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // guest view: count times 8.32 ratio, fraction dropped
  function automatic cea_word_t exp_scale(input cea_word_t c, input cea_ratio_t rt);
    logic [103:0] p;
    p = {40'h0, c} * {64'h0, rt};
    return p[95:32];
  endfunction

  // software average: ratio times wrap-corrected energy delta over cycle delta
  function automatic cea_word_t avg_power(input cea_word_t n, input cea_word_t jfull,
                                          input cea_word_t jx, input cea_word_t jy,
                                          input cea_word_t tx, input cea_word_t ty);
    cea_word_t jd;
    jd = (jy < jx) ? (jy + jfull) - jx : jy - jx;
    return (n * jd) / (ty - tx);
  endfunction

  task automatic chk64(input string nm, input cea_word_t exp, input cea_word_t got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk1(input string nm, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // kind 0 register read, 1 cycle read, 2 write; answer read just after the taking edge
  task automatic xfer(input int kind, input cea_addr_t a, input logic g, input cea_word_t w,
                      output cea_word_t data, output logic flag);
    @(posedge core_clk);
    reg_rd_req               <= (kind == 0);
    cycle_counter_read_instr <= (kind == 1);
    reg_wr_req               <= (kind == 2);
    reg_rd_addr              <= a;
    reg_rd_guest             <= g;
    reg_wr_addr              <= a;
    reg_wr_data              <= w;
    @(posedge core_clk);
    reg_rd_req               <= 1'b0;
    cycle_counter_read_instr <= 1'b0;
    reg_wr_req               <= 1'b0;
    #1;
    data = (kind == 1) ? cycle_rd_data : reg_rd_data;
    flag = (kind == 0) ? reg_rd_err : reg_wr_err;
    if (kind == 0) chk1("read valid", 1'b1, reg_rd_valid);
    if (kind == 1) chk1("cycle valid", 1'b1, cycle_rd_valid);
  endtask

  task automatic resets(input logic por);
    @(posedge core_clk);
    reset_n <= 1'b0;
    por_n   <= ~por;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    por_n   <= 1'b1;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 32'hCBC8C49C;
    core_clk = 1'b0; reset_n = 1'b0; por_n = 1'b0; core_active = 1'b0;
    reg_rd_req = 1'b0; reg_rd_guest = 1'b0; reg_wr_req = 1'b0; cycle_counter_read_instr = 1'b0;
    energy_in = 16'h0000; guest_cycle_scale_ratio = 40'h01_0000_0000;
    reg_rd_addr = 32'h0; reg_wr_addr = 32'h0; reg_wr_data = 64'h0;
    n_mismatch = 0; check_count = 0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    por_n   <= 1'b1;
    @(posedge core_clk);
    // identification and constants
    chk64("ratio id", 64'h0000_0000_0000_0190, {32'h0, sample_to_cycle_ratio});
    chk1("power flag", 1'b1, power_reporting_support_flag);
    xfer(0, ADDR_ENERGY_ACC, 1'b0, 64'h0, d, e);
    chk64("acc power-on", 64'h0, d);
    xfer(0, ADDR_FULL_SCALE, 1'b0, 64'h0, d, e);
    chk64("full scale", 64'h0000_FFFF_FFFF_FFFF, d);
    jmax = d;
    xfer(0, 32'hC001_0E02, 1'b0, 64'h0, d, e);
    chk1("unmapped err", 1'b1, e);
    chk64("unmapped data", 64'h0, d);
    $display("test constants done");
    // max-perf count: write, host, guest and refused writes
    for (int i = 0; i < 8; i++) begin
      v = {rnd(), rnd()};
      r = cea_ratio_t'({rnd(), rnd()});
      if (i == 0) v = 64'hFFFF_FFFF_FFFF_FFFF;
      @(posedge core_clk);
      core_active <= 1'b0;
      guest_cycle_scale_ratio <= r;
      xfer(2, ADDR_MAX_PERF, 1'b0, v, d, e);
      chk1("write ok", 1'b0, e);
      xfer(0, ADDR_MAX_PERF_RO, 1'b0, 64'h0, d, e);
      chk64("view host", v, d);
      xfer(0, ADDR_MAX_PERF_RO, 1'b1, 64'h0, d, e);
      chk64("view guest", exp_scale(v, r), d);
      xfer(0, ADDR_MAX_PERF, 1'b1, 64'h0, d, e);
      chk64("count after guest", v, d);
      xfer(2, ADDR_MAX_PERF_RO, 1'b0, {rnd(), rnd()}, d, e);
      chk1("view write err", 1'b1, e);
      xfer(0, ADDR_MAX_PERF_RO, 1'b0, 64'h0, d, e);
      chk64("view unchanged", v, d);
    end
    $display("test max_perf done");
    // cycle counter and active max-perf count advance by one per cycle
    @(posedge core_clk);
    core_active <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      k = rnd() % 16;
      xfer(1, 32'h0, 1'b0, 64'h0, d0, e);
      repeat (k) @(posedge core_clk);
      xfer(1, 32'h0, 1'b0, 64'h0, d, e);
      chk64("cycle step", d0 + 64'(k + 2), d);
      xfer(0, ADDR_CYCLE_COUNT, 1'b0, 64'h0, v, e);
      chk64("cycle reg", d + 64'h2, v);
      xfer(0, ADDR_MAX_PERF, 1'b0, 64'h0, d0, e);
      repeat (k) @(posedge core_clk);
      xfer(0, ADDR_MAX_PERF, 1'b0, 64'h0, d, e);
      chk64("perf step", d0 + 64'(k + 2), d);
    end
    $display("test counters done");
    // one add of the held energy per 400-cycle window, then the software average
    for (int i = 0; i < 3; i++) begin
      v = {48'h0, 16'(rnd())};
      if (i == 0) v = 64'h0000_0000_0000_FFFF;
      @(posedge core_clk);
      energy_in <= cea_energy_t'(v);
      repeat (3) @(posedge core_clk);
      xfer(0, ADDR_ENERGY_ACC, 1'b0, 64'h0, d0, e);
      xfer(1, 32'h0, 1'b0, 64'h0, t0, e);
      repeat (396) @(posedge core_clk);
      xfer(0, ADDR_ENERGY_ACC, 1'b0, 64'h0, d, e);
      xfer(1, 32'h0, 1'b0, 64'h0, t1, e);
      chk64("acc step", {16'h0, 48'(d0 + v)}, d);
      // interval shortened to the run length; one full period per reading pair
      p = avg_power({32'h0, sample_to_cycle_ratio}, jmax, d0, d, t0, t1);
      chk64("sw power", v, p);
    end
    $display("test energy done");
    // warm reset keeps the accumulator, power-on clears it
    resets(1'b0);
    xfer(0, ADDR_ENERGY_ACC, 1'b0, 64'h0, d0, e);
    resets(1'b0);
    xfer(0, ADDR_ENERGY_ACC, 1'b0, 64'h0, d, e);
    chk64("acc warm reset", d0, d);
    resets(1'b1);
    xfer(0, ADDR_ENERGY_ACC, 1'b0, 64'h0, d, e);
    chk64("acc power-on reset", 64'h0, d);
    $display("test resets done");
    summarize();
  end
endmodule
